/* File: src/rpmc_pkg.sv */
/*
  Shared constants and carrier types of the redriver power and mode control.
  Assumes a 20 MHz control clock and byte-wide register access over the
  serial control interface's internal register port.
*/
// How it works
// - bit 5 forces alternate lane mode
// - alternate mode swing from swing bits 7:5
// - alternate mode pre-emphasis from bits 1:0
// - lane register bits 7:2 give lanes, rate
// - enable low means full power-down
// - enable rising edge resets all state
// - writing bit 3 forces power-down
// - hot-plug low over 2 ms powers down
// - standby: hot-plug high, no clock seen
// - standby keeps clock receiver, control bus and DDC on
// - valid clock after hot-plug means normal
// - gating bit makes hot-plug ignored
// - source hot-plug follows sink outside power-down
// - power-down clears every control register
// - clock activity starts 3 to 5 us check
// - no clock found returns to stage one
package rpmc_pkg;

  localparam logic [7:0] RPMC_MODE_OFS  = 8'h09;
  localparam logic [7:0] RPMC_SWING_OFS = 8'h0c;
  localparam logic [7:0] RPMC_LANE_OFS  = 8'h30;

  localparam int RPMC_ALT_BIT   = 5;
  localparam int RPMC_PD_BIT    = 3;
  localparam int RPMC_GATE_BIT  = 2;
  localparam int RPMC_RATIO_BIT = 1;

  localparam logic [7:0] RPMC_REG_RESET  = 8'h00;
  localparam logic [7:0] RPMC_LANE_ALL   = 8'h3c; // all four lanes on
  localparam logic [1:0] RPMC_RATE_5G4   = 2'h2;  // rate code for 5.4 Gbps

  localparam int CLK_HZ         = 20_000_000;
  localparam int HPD_LOW_US     = 2000;
  localparam int DET_MIN_NS     = 3000;
  localparam int DET_MAX_NS     = 5000;
  // hot-plug low must exceed 2 ms, so add one cycle to the exact count
  localparam int HPD_LOW_CYC    = HPD_LOW_US * (CLK_HZ / 1_000_000) + 1;
  // detection window: at least 3 us (round up), at most 5 us
  localparam int DET_MIN_CYC    = (DET_MIN_NS * (CLK_HZ / 1_000_000)
                                   + 999) / 1000;
  localparam int DET_MAX_CYC    = DET_MAX_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int DET_HITS_MIN   = 8;  // clock edges needed to call it valid

  typedef enum logic [3:0] {
    RPMC_ST_PD    = 4'h1,
    RPMC_ST_STBY1 = 4'h2,
    RPMC_ST_DET   = 4'h4,
    RPMC_ST_NORM  = 4'h8
  } rpmc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpmc_req_t;

  typedef struct packed {
    logic [3:0] lane_en;
    logic [1:0] rate;
    logic [2:0] swing;
    logic [1:0] preemph;
  } rpmc_lane_cfg_t;

  typedef struct packed {
    logic       rx_data_en;
    logic       rx_clk_en;
    logic       tx_en;
    logic       ctl_bus_en;
    logic       ddc_en;
  } rpmc_pwr_t;

endpackage

/* File: src/rpmc_clk_detect.sv */
/*
  Clock-lane activity checker for the standby detection stage.
  Assumes the activity input is already synchronised to clk_i.
*/
module rpmc_clk_detect
  import rpmc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic act_i,
  output logic      done_o,
  output logic      valid_o
);

  logic [7:0] win_q;
  logic [7:0] hits_q;
  logic       act_q;
  logic       busy_q;

  // count activity edges over a window inside the 3..5 us span
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q   <= 8'h00;
      hits_q  <= 8'h00;
      act_q   <= 1'b0;
      busy_q  <= 1'b0;
      done_o  <= 1'b0;
      valid_o <= 1'b0;
    end else begin
      act_q  <= act_i;
      done_o <= 1'b0;
      if (start_i && !busy_q) begin
        busy_q  <= 1'b1;
        win_q   <= 8'h00;
        hits_q  <= 8'h00;
        valid_o <= 1'b0;
      end else if (busy_q) begin
        win_q <= win_q + 8'h01;
        if (act_i && !act_q && hits_q != 8'hff)
          hits_q <= hits_q + 8'h01;
        if (win_q == 8'(DET_MAX_CYC - 1)) begin
          busy_q  <= 1'b0;
          done_o  <= 1'b1;
          valid_o <= (hits_q >= 8'(DET_HITS_MIN));
        end
      end
    end
  end

endmodule

/* File: src/rpmc_top.sv */
/*
  Power mode sequencer and mode registers of a four-lane video redriver.
  Assumes register reads and writes come from the serial control slave as
  one-cycle strobes on clk_i; pins arrive asynchronous and are synchronised.
*/
module rpmc_top
  import rpmc_pkg::*;
#(
  parameter int HPD_LOW_CYCLES = HPD_LOW_CYC
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    out_enable_i,
  input  wire logic                    sink_hotplug_in_i,
  input  wire logic                    clk_lane_act_i,
  input  wire rpmc_pkg::rpmc_req_t     req_i,
  output logic [7:0]                   rdata_o,
  output logic                         rvalid_o,
  output logic                         source_hotplug_out_o,
  output rpmc_pkg::rpmc_state_t        state_o,
  output rpmc_pkg::rpmc_pwr_t          pwr_o,
  output rpmc_pkg::rpmc_lane_cfg_t     lane_cfg_o,
  output logic                         alt_mode_o,
  output logic                         clock_ratio_flag_o
);
  import rpmc_pkg::*;

  logic [1:0]  oe_sync_q;
  logic [1:0]  hpd_sync_q;
  logic [1:0]  act_sync_q;
  logic        oe_q;
  logic        oe_rise;
  logic [7:0]  mode_q;
  logic [7:0]  swing_q;
  logic [7:0]  lane_q;
  logic [15:0] hpd_low_q;
  logic        hpd_timeout;
  logic        hpd_ok;
  logic        pd_req;
  logic        det_start;
  logic        det_done;
  logic        det_valid;
  rpmc_state_t state_q;
  rpmc_state_t state_d;

  // two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_sync_q  <= 2'h0;
      hpd_sync_q <= 2'h0;
      act_sync_q <= 2'h0;
      oe_q       <= 1'b0;
    end else begin
      oe_sync_q  <= {oe_sync_q[0], out_enable_i};
      hpd_sync_q <= {hpd_sync_q[0], sink_hotplug_in_i};
      act_sync_q <= {act_sync_q[0], clk_lane_act_i};
      oe_q       <= oe_sync_q[1];
    end
  end

  assign oe_rise = oe_sync_q[1] && !oe_q;

  // sink hot-plug low timer; counts only while the enable pin is high
  always_ff @(posedge clk_i) begin
    if (rst_i || !oe_sync_q[1] || hpd_sync_q[1])
      hpd_low_q <= 16'h0000;
    else if (hpd_low_q != 16'(HPD_LOW_CYCLES))
      hpd_low_q <= hpd_low_q + 16'h0001;
  end

  // timeout only counts when the gating bit lets hot-plug matter
  // the count lags the synchroniser by one edge, so demand low now as well;
  // otherwise clearing the gate bit just as hot-plug returns powers down
  assign hpd_timeout = (hpd_low_q == 16'(HPD_LOW_CYCLES)) &&
                       !hpd_sync_q[1] &&
                       !mode_q[RPMC_GATE_BIT];
  assign hpd_ok      = mode_q[RPMC_GATE_BIT] || hpd_sync_q[1];
  assign pd_req      = !oe_sync_q[1] || mode_q[RPMC_PD_BIT] ||
                       hpd_timeout;

  // register file; cleared by reset, enable rise and any power-down entry
  always_ff @(posedge clk_i) begin
    if (rst_i || oe_rise || (state_q != RPMC_ST_PD && state_d == RPMC_ST_PD))
    begin
      mode_q  <= RPMC_REG_RESET;
      swing_q <= RPMC_REG_RESET;
      lane_q  <= RPMC_REG_RESET;
    end else if (req_i.wr && oe_sync_q[1]) begin
      unique case (req_i.addr)
        RPMC_MODE_OFS: begin
          mode_q <= req_i.wdata;
          // entering alternate mode self-configures lanes and rate
          if (req_i.wdata[RPMC_ALT_BIT] && !mode_q[RPMC_ALT_BIT])
            lane_q <= {RPMC_LANE_ALL[5:2], RPMC_RATE_5G4, 2'h0};
        end
        RPMC_SWING_OFS: swing_q <= req_i.wdata;
        RPMC_LANE_OFS:  lane_q  <= req_i.wdata;
        default: ;
      endcase
    end
  end

  // read port answers one cycle later; control bus is off while the enable pin is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.rd && oe_sync_q[1];
      unique case (req_i.addr)
        RPMC_MODE_OFS:  rdata_o <= mode_q;
        RPMC_SWING_OFS: rdata_o <= swing_q;
        RPMC_LANE_OFS:  rdata_o <= lane_q;
        default:        rdata_o <= 8'h00;
      endcase
    end
  end

  // next power state; power-down causes win over everything else
  always_comb begin
    state_d   = state_q;
    det_start = 1'b0;
    if (pd_req || oe_rise) begin
      state_d = RPMC_ST_PD;
    end else begin
      unique case (state_q)
        RPMC_ST_PD: begin
          if (hpd_ok)
            state_d = RPMC_ST_STBY1;
        end
        RPMC_ST_STBY1: begin
          if (!hpd_ok)
            state_d = RPMC_ST_STBY1;
          else if (act_sync_q[1]) begin
            state_d   = RPMC_ST_DET;
            det_start = 1'b1;
          end
        end
        RPMC_ST_DET: begin
          if (det_done)
            state_d = det_valid ? RPMC_ST_NORM
                                : RPMC_ST_STBY1;
        end
        RPMC_ST_NORM: begin
          if (!hpd_ok)
            state_d = RPMC_ST_STBY1;
        end
      endcase
    end
  end

  // power state register; reset selects power-down
  always_ff @(posedge clk_i) begin
    if (rst_i)
      state_q <= RPMC_ST_PD;
    else
      state_q <= state_d;
  end

  rpmc_clk_detect u_det (
    .clk_i   (clk_i),
    .rst_i   (rst_i || state_q != RPMC_ST_DET && !det_start),
    .start_i (det_start),
    .act_i   (act_sync_q[1]),
    .done_o  (det_done),
    .valid_o (det_valid)
  );

  // registered outputs derived from the next state to avoid extra lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_o              <= RPMC_ST_PD;
      pwr_o                <= '0;
      source_hotplug_out_o <= 1'b1;
    end else begin
      state_o <= state_d;
      unique case (state_d)
        RPMC_ST_PD:    pwr_o <= '0;
        RPMC_ST_STBY1,
        RPMC_ST_DET:   pwr_o <= 5'b01011;
        RPMC_ST_NORM:  pwr_o <= 5'b11111;
      endcase
      // high in power-down, otherwise a copy of the sink level
      source_hotplug_out_o <= (state_d == RPMC_ST_PD) ? 1'b1
                                                       : hpd_sync_q[1];
    end
  end

  // lane settings; alternate mode takes globals from the registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lane_cfg_o         <= '0;
      alt_mode_o         <= 1'b0;
      clock_ratio_flag_o <= 1'b0;
    end else begin
      alt_mode_o         <= mode_q[RPMC_ALT_BIT];
      clock_ratio_flag_o <= mode_q[RPMC_RATIO_BIT];
      if (mode_q[RPMC_ALT_BIT]) begin
        lane_cfg_o.swing   <= swing_q[7:5];
        lane_cfg_o.preemph <= swing_q[1:0];
        lane_cfg_o.lane_en <= lane_q[7:4] & {4{state_q == RPMC_ST_NORM}};
        lane_cfg_o.rate    <= lane_q[3:2];
      end else begin
        lane_cfg_o.swing   <= 3'h0;
        lane_cfg_o.preemph <= 2'h0;
        lane_cfg_o.lane_en <= {4{state_q == RPMC_ST_NORM}};
        lane_cfg_o.rate    <= 2'h0;
      end
    end
  end

endmodule

/* File: verif/rpmc_sva.sv */
/*
  Assertion checker for rpmc_top, bound to its ports.
  Assumes one clock domain with the synchronous active-high reset.
*/
module rpmc_sva
  import rpmc_pkg::*;
#(
  parameter int HPD_LOW_CYCLES = HPD_LOW_CYC
)
(
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     out_enable_i,
  input wire logic                     sink_hotplug_in_i,
  input wire rpmc_pkg::rpmc_req_t      req_i,
  input wire logic                     source_hotplug_out_o,
  input wire rpmc_pkg::rpmc_state_t    state_o,
  input wire rpmc_pkg::rpmc_pwr_t      pwr_o,
  input wire rpmc_pkg::rpmc_lane_cfg_t lane_cfg_o,
  input wire logic                     alt_mode_o,
  input wire logic                     clock_ratio_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // enable low long enough to pass the synchroniser
  pd_out_a: assert property (!out_enable_i [*6] |->
    state_o == RPMC_ST_PD && pwr_o == '0 && source_hotplug_out_o)
    else $error("power-down outputs wrong");
  pd_clear_a: assert property ($rose(state_o == RPMC_ST_PD) |->
    ##[0:2] !alt_mode_o && !clock_ratio_flag_o)
    else $error("registers kept in power-down");
  pd_write_a: assert property (state_o != RPMC_ST_PD && req_i.wr &&
    req_i.addr == RPMC_MODE_OFS && req_i.wdata[RPMC_PD_BIT]
    |-> ##[1:3] state_o == RPMC_ST_PD) else $error("no power-down");
  stby_pwr_a: assert property ((state_o == RPMC_ST_STBY1) [*2] |->
    pwr_o.rx_clk_en && !pwr_o.rx_data_en && !pwr_o.tx_en &&
    pwr_o.ctl_bus_en) else $error("standby enables wrong");
  norm_pwr_a: assert property ((state_o == RPMC_ST_NORM) [*2] |->
    pwr_o.tx_en && pwr_o.rx_data_en) else $error("normal enables wrong");
  // sink level held steady so the synchroniser delay has run out
  hpd_follow_a: assert property ((state_o != RPMC_ST_PD &&
    $stable(sink_hotplug_in_i)) [*4] |->
    source_hotplug_out_o == sink_hotplug_in_i) else $error("hpd copy");
  alt_rate_a: assert property ($rose(alt_mode_o) |->
    ##[0:2] lane_cfg_o.rate == RPMC_RATE_5G4) else $error("alt rate");
  swing_map_a: assert property (alt_mode_o && req_i.wr &&
    req_i.addr == RPMC_SWING_OFS |-> ##2
    lane_cfg_o.swing == $past(req_i.wdata[7:5], 2) &&
    lane_cfg_o.preemph == $past(req_i.wdata[1:0], 2))
    else $error("swing map wrong");

  cover property (state_o == RPMC_ST_NORM);
  cover property ($fell(state_o == RPMC_ST_DET) &&
    state_o == RPMC_ST_STBY1);
  cover property ($rose(alt_mode_o));
endmodule

bind rpmc_top rpmc_sva #(.HPD_LOW_CYCLES(HPD_LOW_CYCLES)) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .out_enable_i(out_enable_i),
  .sink_hotplug_in_i(sink_hotplug_in_i), .req_i(req_i),
  .source_hotplug_out_o(source_hotplug_out_o), .state_o(state_o),
  .pwr_o(pwr_o), .lane_cfg_o(lane_cfg_o), .alt_mode_o(alt_mode_o),
  .clock_ratio_flag_o(clock_ratio_flag_o));

/* File: verif/rpmc_src_model.sv */
/*
  Behavioural video source driving the clock-lane activity line.
  Assumes mode 0 idle low, 1 a fast clock, 2 a slow square wave toggling every 32 cycles.
*/
module rpmc_src_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  output logic            act_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] cnt_q = 6'h00;
  // lane pattern only; training stays with the source itself
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 6'h01;
    act_o <= (mode_i == 2'h1) ? cnt_q[1] : mode_i[1] && cnt_q[5];
  end
endmodule

/* File: verif/rpmc_top_tb.sv */
/*
  Self-checking bench of rpmc_top with the clock-lane source model.
  Assumes the 20 MHz clock; hot-plug low timeout shortened to 20 cycles.
*/
module rpmc_top_tb;
  import rpmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) chk(16'(g), 16'(e))
  typedef struct packed {logic [7:0] a, d, e;} rpmc_row_t;
  logic clk, rst, oe, hpd, act, rvalid, hpd_o, alt, ratio;
  logic [1:0] mode;
  logic [7:0] rdata, v;
  rpmc_req_t req;
  rpmc_state_t st;
  rpmc_pwr_t pwr;
  rpmc_lane_cfg_t cfg;
  int err_total = 0;
  int compares = 0;
  // unmapped offset last: it must read back zero
  rpmc_row_t rows [4] = '{'{8'h09, 8'h04, 8'h04}, '{8'h0c, 8'ha3, 8'ha3},
    '{8'h30, 8'hfc, 8'hfc}, '{8'h55, 8'h11, 8'h00}};

  rpmc_top #(.HPD_LOW_CYCLES(20)) dut (.clk_i(clk), .rst_i(rst),
    .out_enable_i(oe), .sink_hotplug_in_i(hpd), .clk_lane_act_i(act),
    .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .source_hotplug_out_o(hpd_o), .state_o(st), .pwr_o(pwr),
    .lane_cfg_o(cfg), .alt_mode_o(alt), .clock_ratio_flag_o(ratio));
  rpmc_src_model src (.clk_i(clk), .mode_i(mode), .act_o(act));

  // free-running control clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one-cycle strobes, so a write needs no answer
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1;
    `CHK(rvalid, 1'b1);
    d = rdata;
  endtask
  // bounded wait; running out ends the run as a failure
  task automatic wait_st(input rpmc_state_t s, input int n);
    for (int k = 0; k < n && st !== s; k++) begin
      @(posedge clk);
      #1;
    end
    if (st !== s) begin
      err_total++;
      report_and_stop();
    end
  endtask

  // main sequence
  initial begin
    {rst, oe, hpd, mode, req} = {3'b101, 2'h0, 18'h0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    `CHK(st, RPMC_ST_PD);
    `CHK({hpd_o, pwr}, 6'h20);
    $display("done reset");
    @(posedge clk) oe <= 1'b1;
    wait_st(RPMC_ST_STBY1, 20);
    `CHK({pwr.rx_clk_en, pwr.rx_data_en}, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      `CHK(v, rows[i].e);
    end
    // gate bit now set: losing hot-plug must not power down
    @(posedge clk) hpd <= 1'b0;
    repeat (40) @(posedge clk) #1;
    `CHK({st, hpd_o}, {RPMC_ST_STBY1, 1'b0});
    @(posedge clk) hpd <= 1'b1;
    wr(RPMC_MODE_OFS, 8'h00);
    $display("done registers");
    @(posedge clk) mode <= 2'h2;
    wait_st(RPMC_ST_DET, 80);
    @(posedge clk) mode <= 2'h0;
    wait_st(RPMC_ST_STBY1, 150);
    @(posedge clk) mode <= 2'h1;
    wait_st(RPMC_ST_NORM, 150);
    `CHK(pwr.tx_en, 1'b1);
    $display("done detection");
    wr(RPMC_MODE_OFS, 8'h20);
    repeat (3) @(posedge clk) #1;
    `CHK({alt, cfg.rate}, 3'h6);
    `CHK({alt, cfg.lane_en, cfg.rate}, 7'h7e);
    wr(RPMC_SWING_OFS, 8'he1);
    repeat (3) @(posedge clk) #1;
    `CHK({cfg.swing, cfg.preemph}, 5'h1d);
    wr(RPMC_LANE_OFS, 8'h54);
    repeat (3) @(posedge clk) #1;
    `CHK({cfg.lane_en, cfg.rate}, 6'h15);
    $display("done alternate mode");
    @(posedge clk) hpd <= 1'b0;
    repeat (8) @(posedge clk) #1;
    `CHK({st == RPMC_ST_PD, hpd_o}, 2'h0);
    wait_st(RPMC_ST_PD, 40);
    // the mode outputs follow the cleared registers one edge later
    @(posedge clk) #1;
    `CHK({hpd_o, alt}, 2'h2);
    @(posedge clk) {hpd, mode} <= 3'b100;
    wait_st(RPMC_ST_STBY1, 20);
    $display("done hot-plug loss");
    wr(RPMC_MODE_OFS, 8'h0a);
    wait_st(RPMC_ST_PD, 5);
    wait_st(RPMC_ST_STBY1, 20);
    rd(RPMC_MODE_OFS, v);
    `CHK({v, ratio}, 9'h0);
    wr(RPMC_MODE_OFS, 8'h02);
    repeat (3) @(posedge clk) #1;
    `CHK(ratio, 1'b1);
    @(posedge clk) oe <= 1'b0;
    repeat (6) @(posedge clk) #1;
    `CHK({st, pwr, hpd_o}, {RPMC_ST_PD, 6'h01});
    @(posedge clk) oe <= 1'b1;
    wait_st(RPMC_ST_STBY1, 20);
    `CHK(ratio, 1'b0);
    // host owns the ratio bit again after the enable rise
    wr(RPMC_MODE_OFS, 8'h02);
    repeat (3) @(posedge clk) #1;
    `CHK(ratio, 1'b1);
    $display("done power-down");
    report_and_stop();
  end
endmodule
